// ===== inc/qsp_pkg.sv
// How it works
// [RULE1] Each port has clock, frame sync, two data lines; each line picks tx or rx.
// [RULE2] The bit clock never runs faster than half the core clock.
// [RULE3] DMA moves serial words to and from memory without the core.
// [RULE4] Eight DMA channels, one for each data line of each port.
// [RULE5] TDM mode: ports zero and one receive, ports two and three transmit.
// [RULE6] I2S mode carries two stereo lines per port, sixteen channels in all.
// [RULE7] Bit order is selectable, least or most significant bit first.
// [RULE8] Normal word length ranges from 3 to 32 bits.
// [RULE9] I2S word length ranges from 8 to 32 bits.
// [RULE10] Optional mu-law or A-law companding and selectable frame sync polarity.
// [RULE11] Clock and frame sync are each made inside or taken from outside.
// [RULE12] Finished DMA raises an interrupt; chaining loads the next descriptor itself.
// [RULE13] I2S frame sync is word select; MSB first, one clock after each edge.
`default_nettype none
package qsp_pkg;
  localparam int          NPORT        = 4;
  localparam int          NCH          = 8;
  localparam longint      CLK_HZ       = 200000000;
  localparam longint      SCLK_MAX_HZ  = CLK_HZ / 2;
  localparam int          SCLK_MIN_CYC = int'(CLK_HZ / SCLK_MAX_HZ);
  localparam logic [7:0]  A_PCTRL      = 8'h00;
  localparam logic [7:0]  A_PDIV       = 8'h10;
  localparam logic [7:0]  A_DADDR      = 8'h40;
  localparam logic [7:0]  A_DCNT       = 8'h60;
  localparam logic [7:0]  A_DNEXT      = 8'h80;
  localparam logic [7:0]  A_STAT       = 8'ha0;
  localparam logic [7:0]  A_MASK       = 8'ha4;
  localparam logic [7:0]  A_GCTRL      = 8'ha8;
  localparam int          F_EN         = 0;
  localparam int          F_TX0        = 1;
  localparam int          F_CKI        = 3;
  localparam int          F_FSI        = 4;
  localparam int          F_I2S        = 5;
  localparam int          F_MSB        = 6;
  localparam int          F_CMP        = 7;
  localparam int          F_FSLOW      = 9;
  localparam int          F_WL         = 10;
  localparam logic [31:0] R_PCTRL      = 32'h0000_0000;
  localparam logic [7:0]  R_PDIV       = 8'h00;
  localparam logic [4:0]  WL_MIN       = 5'h02;
  localparam logic [4:0]  WL_I2S_MIN   = 5'h07;
  localparam logic [1:0]  CMP_MU       = 2'h2;
  localparam logic [1:0]  CMP_A        = 2'h3;
  localparam logic [12:0] MU_BIAS      = 13'h0021;
  localparam logic [7:0]  MU_XOR       = 8'hff;
  localparam logic [7:0]  A_XOR        = 8'h55;
  typedef enum logic [1:0] {DS_IDLE, DS_XFER, DS_FETCH} qsp_dma_st_t;
endpackage
`default_nettype wire

// ===== design/qsp_lane.sv
`timescale 1ns/100ps
`default_nettype none
module qsp_lane
  import qsp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        en,
  input  wire logic        is_tx,
  input  wire logic        msb,
  input  wire logic [4:0]  wl,
  input  wire logic        rise,
  input  wire logic        fall,
  input  wire logic        frame,
  input  wire logic [31:0] tx_word,
  input  wire logic        sd_in,
  output logic      [31:0] rx_word,
  output logic             rx_stb,
  output logic             tx_take,
  output logic             sd_out
);
  logic [31:0] sh_r;
  logic [4:0]  cnt_r;
  logic        busy_r;
  logic        pend_r;
  wire  [31:0] sh_in = msb ? {sh_r[30:0], sd_in} : {sd_in, sh_r[31:1]}; // [RULE7]
  wire         last  = cnt_r == 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Shifter: transmit drives on falling edges, receive samples on rising ones.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r    <= 32'h0000_0000;
      cnt_r   <= 5'h00;
      busy_r  <= 1'b0;
      pend_r  <= 1'b0;
      rx_word <= 32'h0000_0000;
      rx_stb  <= 1'b0;
      tx_take <= 1'b0;
    end else begin
      rx_stb  <= 1'b0;
      tx_take <= 1'b0;
      if (!en) begin
        busy_r <= 1'b0;
        pend_r <= 1'b0;
      end else if (is_tx) begin
        if (frame) begin
          pend_r <= 1'b1;
        end else if (fall && pend_r) begin
          sh_r    <= tx_word;
          cnt_r   <= wl;
          busy_r  <= 1'b1;
          pend_r  <= 1'b0;
          tx_take <= 1'b1; // [RULE3]
        end else if (fall && busy_r) begin
          if (last) begin
            busy_r <= 1'b0;
          end else begin
            sh_r  <= msb ? sh_r << 1 : sh_r >> 1; // [RULE7]
            cnt_r <= cnt_r - 5'h01;
          end
        end
      end else begin
        if (frame) begin
          sh_r   <= 32'h0000_0000;
          cnt_r  <= wl; // [RULE8]
          busy_r <= 1'b1;
        end else if (rise && busy_r) begin
          sh_r  <= sh_in;
          cnt_r <= cnt_r - 5'h01;
          if (last) begin
            busy_r  <= 1'b0;
            rx_stb  <= 1'b1;
            rx_word <= msb ? sh_in : sh_in >> (5'h1f - wl); // [RULE7]
          end
        end
      end
    end
  end

  assign sd_out = (busy_r && is_tx) ? (msb ? sh_r[wl] : sh_r[0]) : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_take_on_fall;
    tx_take |-> $past(fall) && $past(pend_r);
  endproperty
  a_take_on_fall: assert property (p_take_on_fall) else $error("load off a fall edge"); // [RULE3]
endmodule
`default_nettype wire

// ===== design/qsp_top.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module qsp_top
  import qsp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic [3:0]  sclk_i,
  output logic      [3:0]  sclk_o,
  output logic      [3:0]  sclk_oe_n,
  input  wire logic [3:0]  fs_i,
  output logic      [3:0]  fs_o,
  output logic      [3:0]  fs_oe_n,
  input  wire logic [7:0]  sd_i,
  output logic      [7:0]  sd_o,
  output logic      [7:0]  sd_oe_n
);
  logic [31:0] pctrl_r [NPORT];
  logic [7:0]  pdiv_r  [NPORT];
  logic [31:0] daddr_r [NCH];
  logic [15:0] dcnt_r  [NCH];
  logic [31:0] dnext_r [NCH];
  logic [31:0] hold_r  [NCH];
  logic [4:0]  wl_e    [NPORT];
  logic [7:0]  full_r;
  logic [7:0]  stat_r;
  logic [7:0]  mask_r;
  logic        tdm_r;
  logic [15:0] pin_m;
  logic [15:0] pin_s;
  logic [3:0]  ck_d;
  logic [3:0]  en, cki, fsi, i2s, msb_e, fsl;
  logic [3:0]  rise_l, fall_l, fsv_l, rise, fall, fsv, frame;
  logic [7:0]  tx, req, upd, take, stb, done;
  logic [2:0]  ld [NCH];

  function automatic logic [7:0] compress(input logic alaw, input logic [15:0] x);
    logic [12:0] m;
    logic [2:0]  seg;
    logic [3:0]  q;
    m = x[15] ? ~x[14:2] : x[14:2];
    if (!alaw) m = (m > 13'h1fff - MU_BIAS) ? 13'h1fff : m + MU_BIAS;
    seg = 3'h0;
    for (int i = 1; i < 8; i++) if (m[i+4]) seg = 3'(i);
    q = 4'(m >> ((seg == 3'h0) ? 3'h1 : seg));
    return {x[15], seg, q} ^ (alaw ? A_XOR : MU_XOR);
  endfunction

  function automatic logic [31:0] expand(input logic alaw, input logic [7:0] c);
    logic [7:0]  y;
    logic [12:0] m;
    logic [15:0] v;
    y = c ^ (alaw ? A_XOR : MU_XOR);
    m = (y[6:4] == 3'h0) ? {8'h00, y[3:0], 1'b1} : 13'({1'b1, y[3:0], 1'b1} << (y[6:4] - 3'h1));
    if (!alaw) m = (m < MU_BIAS) ? 13'h0000 : m - MU_BIAS;
    v = {y[7], y[7] ? ~m : m, 2'b00};
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) if (v[i]) r = 3'(i);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Zero wait states; read data is captured in the setup cycle.
  wire       wr_en = psel & penable & pwrite;
  wire [1:0] pi    = paddr[3:2];
  wire [2:0] ci    = paddr[4:2];
  wire       pc_hit = paddr[7:4] == A_PCTRL[7:4];
  wire       pd_hit = paddr[7:4] == A_PDIV[7:4];
  wire       da_hit = paddr[7:5] == A_DADDR[7:5];
  wire       dc_hit = paddr[7:5] == A_DCNT[7:5];
  wire       dn_hit = paddr[7:5] == A_DNEXT[7:5];
  wire       st_hit = paddr == A_STAT;
  wire       mk_hit = paddr == A_MASK;
  wire       gc_hit = paddr == A_GCTRL;
  wire       map_hit = pc_hit | pd_hit | da_hit | dc_hit | dn_hit | st_hit | mk_hit | gc_hit;
  wire [31:0] rd_val = pc_hit ? pctrl_r[pi] :
                       pd_hit ? {24'h000000, pdiv_r[pi]} :
                       da_hit ? daddr_r[ci] :
                       dc_hit ? {16'h0000, dcnt_r[ci]} :
                       dn_hit ? dnext_r[ci] :
                       st_hit ? {24'h000000, stat_r} :
                       mk_hit ? {24'h000000, mask_r} :
                       gc_hit ? {31'h00000000, tdm_r} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~map_hit;
  assign irq     = |(stat_r & mask_r); // [RULE12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      stat_r <= 8'h00;
      mask_r <= 8'h00;
      tdm_r  <= 1'b0;
    end else begin
      if (psel && !penable) prdata <= rd_val;
      stat_r <= (stat_r & ~((wr_en && st_hit) ? pwdata[7:0] : 8'h00)) | done; // [RULE12]
      if (wr_en && mk_hit) mask_r <= pwdata[7:0];
      if (wr_en && gc_hit) tdm_r <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin; a third flop finds clock edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m <= 16'h0000;
      pin_s <= 16'h0000;
      ck_d  <= 4'h0;
    end else begin
      pin_m <= {sd_i, fs_i, sclk_i};
      pin_s <= pin_m;
      ck_d  <= pin_s[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port configuration, clock and frame sync generation.
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam int S = p % 2;
    logic [7:0] dv_r;
    logic       ck_r, fs_r, fp_r;
    logic [4:0] bc_r;
    wire  [4:0] wl_raw = pctrl_r[p][F_WL +: 5];
    wire        slave  = (p >= 2) && tdm_r;
    wire        tick   = en[p] && (dv_r == pdiv_r[p]);

    assign en[p]    = pctrl_r[p][F_EN];
    assign cki[p]   = pctrl_r[p][F_CKI];
    assign fsi[p]   = pctrl_r[p][F_FSI];
    assign i2s[p]   = pctrl_r[p][F_I2S];
    assign fsl[p]   = pctrl_r[p][F_FSLOW];
    assign msb_e[p] = pctrl_r[p][F_MSB] | i2s[p]; // [RULE13]
    assign wl_e[p]  = i2s[p] ? ((wl_raw < WL_I2S_MIN) ? WL_I2S_MIN : wl_raw) // [RULE9]
                             : ((wl_raw < WL_MIN) ? WL_MIN : wl_raw); // [RULE8]
    assign rise_l[p] = cki[p] ? (tick && !ck_r) : (en[p] && pin_s[p] && !ck_d[p]); // [RULE11]
    assign fall_l[p] = cki[p] ? (tick && ck_r) : (en[p] && !pin_s[p] && ck_d[p]); // [RULE11]
    assign fsv_l[p]  = (fsi[p] ? fs_r : pin_s[4+p]) ^ fsl[p]; // [RULE10]
    assign rise[p]   = slave ? rise_l[S] : rise_l[p]; // [RULE5]
    assign fall[p]   = slave ? fall_l[S] : fall_l[p]; // [RULE5]
    assign fsv[p]    = slave ? fsv_l[S] : fsv_l[p]; // [RULE5]
    assign frame[p]  = rise[p] && (i2s[p] ? (fsv[p] != fp_r) : (fsv[p] && !fp_r)); // [RULE13]
    assign sclk_o[p]    = ck_r;
    assign sclk_oe_n[p] = ~(en[p] & cki[p] & ~slave); // [RULE11]
    assign fs_o[p]      = fs_r ^ fsl[p];
    assign fs_oe_n[p]   = ~(en[p] & fsi[p] & ~slave); // [RULE11]

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pctrl_r[p] <= R_PCTRL;
        pdiv_r[p]  <= R_PDIV;
      end else if (wr_en && pi == 2'(p)) begin
        if (pc_hit) pctrl_r[p] <= pwdata;
        if (pd_hit) pdiv_r[p] <= pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dv_r <= 8'h00;
        ck_r <= 1'b0;
      end else if (!en[p] || tick) begin
        dv_r <= 8'h00;
        ck_r <= en[p] & ~ck_r; // [RULE2]
      end else begin
        dv_r <= dv_r + 8'h01;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bc_r <= 5'h00;
        fs_r <= 1'b0;
        fp_r <= 1'b0;
      end else begin
        if (rise[p]) fp_r <= fsv[p];
        if (!en[p]) begin
          bc_r <= 5'h00;
          fs_r <= 1'b0;
        end else if (fall_l[p]) begin
          bc_r <= (bc_r == wl_e[p]) ? 5'h00 : bc_r + 5'h01;
          if (bc_r == wl_e[p]) fs_r <= i2s[p] ? ~fs_r : 1'b1; // [RULE13]
          else if (!i2s[p]) fs_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data lines and their DMA channels; channel c is line c%2 of port c/2.
  for (genvar c = 0; c < NCH; c++) begin : g_chan // [RULE4]
    localparam int P = c / 2;
    logic [31:0] rxw;
    wire  [1:0]  law = pctrl_r[P][F_CMP +: 2];
    wire         cmp = (law == CMP_MU) || (law == CMP_A); // [RULE10]
    wire  [31:0] txw = cmp ? {24'h000000, compress(law == CMP_A, hold_r[c][15:0])} : hold_r[c];
    wire         set = tx[c] ? upd[c] : stb[c];
    wire         clr = tx[c] ? take[c] : upd[c];

    assign tx[c]  = tdm_r ? (P >= 2) : pctrl_r[P][F_TX0 + (c % 2)]; // [RULE1] [RULE5]
    assign req[c] = en[P] && (dcnt_r[c] != 16'h0000) && (tx[c] ? !full_r[c] : full_r[c]);
    assign sd_oe_n[c] = ~(en[P] & tx[c]); // [RULE1]

    qsp_lane u_lane (
      .pclk    (pclk),
      .presetn (presetn),
      .en      (en[P]),
      .is_tx   (tx[c]),
      .msb     (msb_e[P]),
      .wl      (wl_e[P]),
      .rise    (rise[P]),
      .fall    (fall[P]),
      .frame   (frame[P]), // [RULE6]
      .tx_word (txw),
      .sd_in   (pin_s[8+c]),
      .rx_word (rxw),
      .rx_stb  (stb[c]),
      .tx_take (take[c]),
      .sd_out  (sd_o[c])
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        daddr_r[c] <= 32'h0000_0000;
        dcnt_r[c]  <= 16'h0000;
        dnext_r[c] <= 32'h0000_0000;
        hold_r[c]  <= 32'h0000_0000;
        full_r[c]  <= 1'b0;
      end else begin
        if (wr_en && da_hit && ci == 3'(c)) daddr_r[c] <= pwdata;
        else if (upd[c]) daddr_r[c] <= daddr_r[c] + 32'h0000_0004;
        else if (ld[c][0]) daddr_r[c] <= mem_rdata; // [RULE12]
        if (wr_en && dc_hit && ci == 3'(c)) dcnt_r[c] <= pwdata[15:0];
        else if (upd[c]) dcnt_r[c] <= dcnt_r[c] - 16'h0001;
        else if (ld[c][1]) dcnt_r[c] <= mem_rdata[15:0]; // [RULE12]
        if (wr_en && dn_hit && ci == 3'(c)) dnext_r[c] <= pwdata;
        else if (ld[c][2]) dnext_r[c] <= mem_rdata; // [RULE12]
        if (set) hold_r[c] <= tx[c] ? mem_rdata : (cmp ? expand(law == CMP_A, rxw[7:0]) : rxw);
        full_r[c] <= set | (full_r[c] & ~clr); // [RULE3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA engine: one memory port, lowest channel first, descriptor chaining.
  qsp_dma_st_t st_r;
  logic [2:0]  ch_r;
  logic [1:0]  fk_r;
  wire  [2:0]  pick = first_set(req);
  wire         last = dcnt_r[ch_r] == 16'h0001;
  wire         chain_last = last && dnext_r[ch_r][0];

  for (genvar c = 0; c < NCH; c++) begin : g_eng
    wire ours = ch_r == 3'(c);
    assign upd[c]  = (st_r == DS_XFER) && mem_ack && ours;
    assign done[c] = upd[c] && last; // [RULE12]
    for (genvar k = 0; k < 3; k++) begin : g_ld
      assign ld[c][k] = (st_r == DS_FETCH) && mem_ack && ours && (fk_r == 2'(k));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= DS_IDLE;
      ch_r      <= 3'h0;
      fk_r      <= 2'h0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else begin
      unique case (st_r)
        DS_IDLE: if (|req) begin
          ch_r      <= pick;
          mem_req   <= 1'b1; // [RULE3]
          mem_we    <= ~tx[pick];
          mem_addr  <= daddr_r[pick];
          mem_wdata <= hold_r[pick];
          st_r      <= DS_XFER;
        end
        DS_XFER: if (mem_ack) begin
          mem_req <= chain_last;
          mem_we  <= 1'b0;
          fk_r    <= 2'h0;
          if (chain_last) mem_addr <= {dnext_r[ch_r][31:2], 2'b00}; // [RULE12]
          st_r    <= chain_last ? DS_FETCH : DS_IDLE;
        end
        DS_FETCH: if (mem_ack) begin
          mem_addr <= mem_addr + 32'h0000_0004;
          fk_r     <= fk_r + 2'h1;
          if (fk_r == 2'h2) begin
            mem_req <= 1'b0;
            st_r    <= DS_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] gap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= 8'hff;
    else if (rise[0]) gap_r <= 8'h00;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end

  property p_gap;
    rise[0] |-> gap_r >= 8'(SCLK_MIN_CYC - 1);
  endproperty
  a_gap: assert property (p_gap) else $error("bit clock above half core rate"); // [RULE2]
  property p_ext_clk;
    ($rose(sclk_i[1]) && en[1] && !cki[1]) [*1] ##1 (en[1] && !cki[1]) |-> ##1 rise_l[1];
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("external clock edge lost"); // [RULE11]
  property p_wl;
    wl_e[0] >= WL_MIN && wl_e[1] >= WL_MIN;
  endproperty
  a_wl: assert property (p_wl) else $error("word length below minimum"); // [RULE8]
  property p_i2s_wl;
    i2s[0] |-> wl_e[0] >= WL_I2S_MIN && msb_e[0];
  endproperty
  a_i2s_wl: assert property (p_i2s_wl) else $error("bad I2S word format"); // [RULE9]
  property p_order;
    (!i2s[1] && !pctrl_r[1][F_MSB]) |-> !msb_e[1];
  endproperty
  a_order: assert property (p_order) else $error("bit order not honoured"); // [RULE7]
  property p_tdm;
    tdm_r |-> !tx[0] && !tx[1] && tx[4] && tx[5] && rise[2] == rise[0] && fsv[3] == fsv[1];
  endproperty
  a_tdm: assert property (p_tdm) else $error("TDM pairing broken"); // [RULE5]
  property p_irq;
    (|(done & mask_r)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing completion interrupt"); // [RULE12]
  property p_sticky;
    (|done) |=> (stat_r & $past(done)) == $past(done);
  endproperty
  a_sticky: assert property (p_sticky) else $error("done bit lost"); // [RULE12]
  property p_chain;
    (st_r == DS_XFER && mem_ack && chain_last) |=> st_r == DS_FETCH && mem_req && !mem_we;
  endproperty
  a_chain: assert property (p_chain) else $error("chain fetch not started"); // [RULE12]
  property p_hold_req;
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("memory request dropped"); // [RULE3]

  c_done:  cover property (|done);
  c_chain: cover property (st_r == DS_FETCH && mem_ack && fk_r == 2'h2);
  c_i2s:   cover property (frame[0] && i2s[0]);
  c_tdm:   cover property (tdm_r && frame[2]);
endmodule
`default_nettype wire

// ===== testbench/qsp_codec_model.sv
`timescale 1ns/100ps
`default_nettype none
module qsp_codec_model (
  output logic sclk,
  output logic fs,
  output logic sd
);
  initial begin
    sclk = 1'b0;
    fs   = 1'b0;
    sd   = 1'b0;
  end
  // Sends one 8-bit word, first bit w[7]; clock stands still outside the frame.
  task automatic send(input logic [7:0] w);
    #1;
    fs = 1'b1;
    #80 sclk = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #80 sclk = 1'b0;
      fs = 1'b0;
      sd = w[i];
      #80 sclk = 1'b1;
    end
    #80 sclk = 1'b0;
    sd = ~sd;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import qsp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        mem_ack = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, mem_addr, mem_wdata, rd, m_addr, m_data;
  logic        pready, pslverr, irq, mem_req, mem_we, m_we, err, c_sclk, c_fs, c_sd, prev;
  logic [3:0]  sclk_o, sclk_oe_n, fs_o, fs_oe_n;
  logic [7:0]  sd_o, sd_oe_n;
  logic        sclk_r, ws;
  wire  [31:0] m_rdata = (mem_addr == 32'h200) ? 32'ha5 :
                         (mem_addr == 32'h300) ? 32'h400 : 32'h0;
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_mem = 0;
  int          cyc = 0;
  int          k;
  always #2.5 pclk = ~pclk;
  qsp_codec_model u_codec (.sclk(c_sclk), .fs(c_fs), .sd(c_sd));
  qsp_top dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(m_rdata), .mem_ack(mem_ack),
    .sclk_i({2'h0, c_sclk, 1'h0}), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
    .fs_i({2'h0, c_fs, 1'h0}), .fs_o(fs_o), .fs_oe_n(fs_oe_n),
    .sd_i({5'h0, c_sd, 2'h0}), .sd_o(sd_o), .sd_oe_n(sd_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Memory answers each request one cycle later, records it and returns fixed read data.
  always @(posedge pclk) begin
    mem_ack <= mem_req & ~mem_ack;
    if (mem_req & mem_ack) begin
      m_addr <= mem_addr;
      m_data <= mem_wdata;
      m_we   <= mem_we;
      n_mem  <= n_mem + 1;
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sclk_r <= sclk_o[0];
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rise0();
    ws = fs_o[0];
    do @(posedge pclk); while (sclk_o[0] !== 1'b1 || sclk_r !== 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("irq", {31'h0, irq}, 32'h0);
    chk("sclk_oe_n", {28'h0, sclk_oe_n}, 32'hf);
    apb(1'b0, A_PCTRL, 32'h0);
    chk("pctrl0", rd, R_PCTRL);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    apb(1'b1, A_PDIV, 32'h1);
    apb(1'b1, A_PCTRL, 32'h19);
    repeat (8) @(posedge pclk);
    chk("sclk_oe_n0", {31'h0, sclk_oe_n[0]}, 32'h0);
    chk("fs_oe_n0", {31'h0, fs_oe_n[0]}, 32'h0);
    k = 0;
    prev = sclk_o[0];
    repeat (16) begin
      @(posedge pclk);
      if (sclk_o[0] === 1'b1 && prev === 1'b0) k++;
      prev = sclk_o[0];
    end
    chk("sclk rises", k, 32'h4);
    apb(1'b1, A_PCTRL, 32'h0);
    $display("test internal clock done");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, A_MASK, m ? 32'h4 : 32'h0);
      apb(1'b1, A_PCTRL + 8'h04, 32'h1c01 | (m ? 32'h40 : 32'h0));
      apb(1'b1, A_DADDR + 8'h08, 32'h100);
      apb(1'b1, A_DCNT + 8'h08, 32'h1);
      k = n_mem;
      u_codec.send(8'h96);
      for (int t = 0; t < 200 && n_mem == k; t++) @(posedge pclk);
      chk("mem words", n_mem - k, 32'h1);
      chk("mem addr", m_addr, 32'h100);
      chk("mem we", {31'h0, m_we}, 32'h1);
      chk("rx word", m_data, m ? 32'h96 : 32'h69);
      apb(1'b0, A_STAT, 32'h0);
      chk("stat", rd, 32'h4);
      chk("irq", {31'h0, irq}, m);
      apb(1'b1, A_STAT, 32'h4);
      apb(1'b0, A_STAT, 32'h0);
      chk("stat cleared", rd, 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    $display("test receive dma done");
    apb(1'b1, A_DADDR, 32'h200);
    apb(1'b1, A_DCNT, 32'h1);
    apb(1'b1, A_DNEXT, 32'h301);
    k = n_mem;
    apb(1'b1, A_PCTRL, 32'h3b);
    repeat (2) do rise0(); while (fs_o[0] === ws);
    rd = 32'h0;
    repeat (8) begin
      rise0();
      rd = {rd[30:0], sd_o[0]};
    end
    chk("i2s tx word", rd, 32'ha5);
    chk("sd_oe_n0", {31'h0, sd_oe_n[0]}, 32'h0);
    chk("chain reads", n_mem - k, 32'h4);
    chk("chain last addr", m_addr, 32'h308);
    chk("read we", {31'h0, m_we}, 32'h0);
    apb(1'b0, A_DADDR, 32'h0);
    chk("chained addr", rd, 32'h400);
    apb(1'b0, A_STAT, 32'h0);
    chk("tx done", rd, 32'h1);
    apb(1'b1, A_PCTRL, 32'h0);
    $display("test i2s transmit done");
    apb(1'b1, A_GCTRL, 32'h1);
    apb(1'b1, A_PCTRL + 8'h08, 32'h19);
    @(posedge pclk);
    chk("tdm slave clock", {31'h0, sclk_oe_n[2]}, 32'h1);
    chk("tdm tx lines", {30'h0, sd_oe_n[5:4]}, 32'h0);
    apb(1'b1, A_PCTRL + 8'h08, 32'h0);
    apb(1'b1, A_GCTRL, 32'h0);
    $display("test tdm done");
    end_sim();
  end
endmodule
`default_nettype wire
